//--- verilog/wdtim_pkg.sv
// constants, field layout and bus carrier for the watchdog interval timer
package wdtim_pkg;
	// read byte addresses (low 20 bits)
	localparam logic [19:0] ADDR_CTRL_RD = 20'hfff8c;
	localparam logic [19:0] ADDR_COUNT_RD = 20'hfff8d;
	localparam logic [19:0] ADDR_RSTAT_RD = 20'hfff8f;
	// word write addresses
	localparam logic [19:0] ADDR_CNTCTL_WR = 20'hfff8c;
	localparam logic [19:0] ADDR_RSTAT_WR = 20'hfff8e;
	// passwords carried in the high byte, clear data in the low byte
	localparam logic [7:0] PASS_COUNT = 8'h5a;
	localparam logic [7:0] PASS_CTRL = 8'ha5;
	localparam logic [7:0] PASS_RST_CLR = 8'ha5;
	localparam logic [7:0] PASS_RST_OE = 8'h5a;
	localparam logic [7:0] RST_CLR_DATA = 8'h00;
	// control register fields
	localparam int CTRL_WRAP_BIT = 7;
	localparam int CTRL_MODE_BIT = 6;
	localparam int CTRL_RUN_BIT = 5;
	localparam logic [7:0] CTRL_FIXED_ONES = 8'h18;
	localparam logic [7:0] CTRL_RESET = 8'h18;
	// reset status register fields, counter reset and maximum
	localparam int RSTAT_FLAG_BIT = 7;
	localparam int RSTAT_OE_BIT = 6;
	localparam logic [7:0] RSTAT_FIXED_ONES = 8'h3f;
	localparam logic [7:0] RSTAT_RESET = 8'h3f;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	// prescaler and internal reset length
	localparam int PRESC_W = 12;
	localparam int CHIP_RESET_STATES = 518;
	localparam logic [9:0] CHIP_RESET_CYCLES = 10'(CHIP_RESET_STATES);
	// bus access from the cpu side
	typedef struct packed {
		logic wr_word;
		logic wr_byte;
		logic rd_byte;
		logic t3;
		logic [19:0] addr;
		logic [15:0] wdata;
	} wdtim_bus_t;
endpackage : wdtim_pkg

//--- verilog/wdtim_top.sv
// watchdog and interval timer with password-protected registers
`timescale 1ns/1ps
module wdtim_top (
	// clock and resets
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic standby_i,
	// cpu access
	input wire wdtim_pkg::wdtim_bus_t bus_i,
	output logic [7:0] rdata_o,
	// events
	output logic interval_wrap_irq_o,
	output logic chip_reset_o,
	output logic reset_output_enable_o
);
	import wdtim_pkg::*;

	logic [PRESC_W-1:0] presc_reg;
	logic [PRESC_W-1:0] presc_next;
	logic [7:0] watchdog_count_reg;
	logic [2:0] clock_select_field_reg;
	logic timer_mode_select_reg;
	logic count_run_enable_reg;
	logic count_wrap_flag_reg;
	logic watchdog_reset_flag_reg;
	logic reset_output_enable_reg;
	logic wrap_seen_one_reg;
	logic watchdog_reset_flag_seen_one_reg;
	logic [9:0] chip_rst_cnt_reg;
	logic tick;
	logic wrap;
	logic wd_fire;
	logic int_rst;
	logic wr_count;
	logic wr_ctrl;
	logic wr_rst_clr;
	logic wr_rst_oe;
	logic rd_ctrl;
	logic rd_rstat;
	logic [7:0] ctrl_view;
	logic [7:0] rstat_view;

	// returns one on the rising edge of the prescaler bit that gives the chosen rate
	function automatic logic tap_edge(input logic [2:0] sel,
			input logic [PRESC_W-1:0] cur, input logic [PRESC_W-1:0] nxt);
		int idx;
		idx = 0;
		unique case (sel)
			3'h0: idx = 0;
			3'h1: idx = 4;
			3'h2: idx = 5;
			3'h3: idx = 6;
			3'h4: idx = 7;
			3'h5: idx = 8;
			3'h6: idx = 10;
			3'h7: idx = 11;
		endcase
		tap_edge = !cur[idx] && nxt[idx];
	endfunction : tap_edge

	// internal chip reset acts on this block too, except the prescaler, the reset flag and the output enable
	assign int_rst = (chip_rst_cnt_reg != 10'h000);
	assign presc_next = presc_reg + {{(PRESC_W-1){1'b0}}, 1'b1};
	assign tick = count_run_enable_reg && tap_edge(clock_select_field_reg, presc_reg, presc_next);

	assign wr_count = bus_i.wr_word && bus_i.addr == ADDR_CNTCTL_WR
		&& bus_i.wdata[15:8] == PASS_COUNT;
	assign wr_ctrl = bus_i.wr_word && bus_i.addr == ADDR_CNTCTL_WR
		&& bus_i.wdata[15:8] == PASS_CTRL;
	assign wr_rst_clr = bus_i.wr_word && bus_i.addr == ADDR_RSTAT_WR
		&& bus_i.wdata[15:8] == PASS_RST_CLR && bus_i.wdata[7:0] == RST_CLR_DATA;
	assign wr_rst_oe = bus_i.wr_word && bus_i.addr == ADDR_RSTAT_WR
		&& bus_i.wdata[15:8] == PASS_RST_OE;
	assign rd_ctrl = bus_i.rd_byte && bus_i.addr == ADDR_CTRL_RD;
	assign rd_rstat = bus_i.rd_byte && bus_i.addr == ADDR_RSTAT_RD;

	// wrap on the tick that leaves all ones (a count write with t3 suppresses it)
	assign wrap = tick && watchdog_count_reg == COUNT_MAX && !(wr_count && bus_i.t3);
	// watchdog fire needs mode and run enable
	assign wd_fire = wrap && timer_mode_select_reg && count_run_enable_reg;

	assign ctrl_view = CTRL_FIXED_ONES | {count_wrap_flag_reg, timer_mode_select_reg,
		count_run_enable_reg, 2'b00, clock_select_field_reg};
	assign rstat_view = RSTAT_FIXED_ONES | {watchdog_reset_flag_reg, reset_output_enable_reg, 6'h00};

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			presc_reg <= '0;
		end else begin
			presc_reg <= presc_next;
		end
	end

	// counter
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || int_rst || standby_i) begin
			watchdog_count_reg <= COUNT_RESET;
		end else if (wr_count) begin
			watchdog_count_reg <= bus_i.wdata[7:0];
		end else if (!count_run_enable_reg) begin
			watchdog_count_reg <= COUNT_RESET;
		end else if (tick) begin
			watchdog_count_reg <= watchdog_count_reg + 8'h01;
		end
	end

	// control bits 6 and 5
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || int_rst || standby_i) begin
			timer_mode_select_reg <= CTRL_RESET[CTRL_MODE_BIT];
			count_run_enable_reg <= CTRL_RESET[CTRL_RUN_BIT];
		end else if (wr_ctrl) begin
			timer_mode_select_reg <= bus_i.wdata[CTRL_MODE_BIT];
			count_run_enable_reg <= bus_i.wdata[CTRL_RUN_BIT];
		end
	end

	// clock select keeps its value through standby
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || int_rst) begin
			clock_select_field_reg <= CTRL_RESET[2:0];
		end else if (wr_ctrl) begin
			clock_select_field_reg <= bus_i.wdata[2:0];
		end
	end

	// wrap flag with read-one-then-write-zero clearing
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || int_rst || standby_i) begin
			count_wrap_flag_reg <= 1'b0;
			wrap_seen_one_reg <= 1'b0;
		end else if (wrap) begin
			// set wins over a clear in the same cycle
			count_wrap_flag_reg <= 1'b1;
		end else begin
			if (rd_ctrl && count_wrap_flag_reg) begin
				wrap_seen_one_reg <= 1'b1;
			end
			// clear after read of one; writing one does nothing
			if (wr_ctrl && !bus_i.wdata[CTRL_WRAP_BIT] && wrap_seen_one_reg) begin
				count_wrap_flag_reg <= 1'b0;
				wrap_seen_one_reg <= 1'b0;
			end
		end
	end

	// reset flag survives the internal reset, only the pin or the password clear clears it
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			watchdog_reset_flag_reg <= RSTAT_RESET[RSTAT_FLAG_BIT];
			watchdog_reset_flag_seen_one_reg <= 1'b0;
			reset_output_enable_reg <= RSTAT_RESET[RSTAT_OE_BIT];
		end else begin
			if (wd_fire && !int_rst) begin
				watchdog_reset_flag_reg <= 1'b1;
			end else begin
				if (rd_rstat && watchdog_reset_flag_reg) begin
					watchdog_reset_flag_seen_one_reg <= 1'b1;
				end
				// password clear after read of one
				if (wr_rst_clr && watchdog_reset_flag_seen_one_reg) begin
					watchdog_reset_flag_reg <= 1'b0;
					watchdog_reset_flag_seen_one_reg <= 1'b0;
				end
			end
			if (wr_rst_oe) begin
				reset_output_enable_reg <= bus_i.wdata[RSTAT_OE_BIT];
			end
		end
	end

	// internal chip reset stretch
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			chip_rst_cnt_reg <= 10'h000;
		end else if (wd_fire && !int_rst) begin
			chip_rst_cnt_reg <= CHIP_RESET_CYCLES;
		end else if (int_rst) begin
			chip_rst_cnt_reg <= chip_rst_cnt_reg - 10'h001;
		end
	end

	// registered outputs
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			chip_reset_o <= 1'b0;
			interval_wrap_irq_o <= 1'b0;
			reset_output_enable_o <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			chip_reset_o <= (wd_fire && !int_rst) || chip_rst_cnt_reg > 10'h001;
			// irq follows the wrap flag in interval mode
			interval_wrap_irq_o <= (count_wrap_flag_reg || wrap) && !timer_mode_select_reg
				&& !int_rst;
			reset_output_enable_o <= reset_output_enable_reg;
			if (rd_ctrl) begin
				rdata_o <= ctrl_view;
			end else if (bus_i.rd_byte && bus_i.addr == ADDR_COUNT_RD) begin
				rdata_o <= watchdog_count_reg;
			end else if (rd_rstat) begin
				rdata_o <= rstat_view;
			end else begin
				rdata_o <= 8'h00;
			end
		end
	end
endmodule : wdtim_top

//--- testbench/wdtim_checker.sv
// port assertions for the watchdog interval timer
`timescale 1ns/1ps
module wdtim_checker (
	// clock and resets
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic standby_i,
	// cpu access and events
	input wire wdtim_pkg::wdtim_bus_t bus_i,
	input wire logic [7:0] rdata_o,
	input wire logic interval_wrap_irq_o,
	input wire logic chip_reset_o,
	input wire logic reset_output_enable_o
);
	import wdtim_pkg::*;
	logic [9:0] hi_reg;
	logic oe_wr;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	assign oe_wr = bus_i.wr_word && bus_i.addr == ADDR_RSTAT_WR && bus_i.wdata[15:8] == PASS_RST_OE;
	// length of the current internal reset, cleared by the pin reset
	always_ff @(posedge clock_i) begin
		hi_reg <= (rst_n_i && chip_reset_o) ? hi_reg + 10'h001 : 10'h000;
	end
	idle_read_a: assert property (!bus_i.rd_byte |=> rdata_o == 8'h00)
		else $error("read data not idle");
	ctrl_ones_a: assert property (bus_i.rd_byte && bus_i.addr == ADDR_CTRL_RD |=> rdata_o[4:3] == 2'b11)
		else $error("control fixed bits not one");
	rstat_ones_a: assert property (bus_i.rd_byte && bus_i.addr == ADDR_RSTAT_RD |=> rdata_o[5:0] == 6'h3f)
		else $error("reset status fixed bits not one");
	chip_len_a: assert property ($fell(chip_reset_o) && $past(rst_n_i) |-> hi_reg == CHIP_RESET_CYCLES)
		else $error("internal reset length wrong");
	chip_cap_a: assert property (chip_reset_o |-> hi_reg < CHIP_RESET_CYCLES)
		else $error("internal reset too long");
	chip_irq_a: assert property (chip_reset_o |-> !interval_wrap_irq_o)
		else $error("interrupt during internal reset");
	irq_hold_a: assert property ($fell(interval_wrap_irq_o) |-> $past(bus_i.wr_word) || $past(bus_i.wr_word, 2)
		|| $past(standby_i) || $past(standby_i, 2) || !$past(rst_n_i)) else $error("interrupt dropped alone");
	oe_src_a: assert property ($changed(reset_output_enable_o) |-> $past(oe_wr) || $past(oe_wr, 2)
		|| !$past(rst_n_i) || !$past(rst_n_i, 2)) else $error("output enable changed alone");
	cover property ($rose(chip_reset_o));
	cover property ($rose(interval_wrap_irq_o));
	cover property ($rose(reset_output_enable_o));
endmodule : wdtim_checker
bind wdtim_top wdtim_checker chk_i (.clock_i, .rst_n_i, .standby_i, .bus_i, .rdata_o,
	.interval_wrap_irq_o, .chip_reset_o, .reset_output_enable_o);

//--- testbench/wdtim_top_tb.sv
// self-checking bench for the watchdog interval timer
`timescale 1ns/1ps
module wdtim_top_tb;
	import wdtim_pkg::*;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic standby_i = 1'b0;
	wdtim_bus_t bus_i = '0;
	logic [7:0] rdata_o;
	logic irq;
	logic chip;
	logic oe;
	int num_errors = 0;
	int compares = 0;
	int divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
	wdtim_top uut (.clock_i, .rst_n_i, .standby_i, .bus_i, .rdata_o,
		.interval_wrap_irq_o(irq), .chip_reset_o(chip), .reset_output_enable_o(oe));
	always #25 clock_i = ~clock_i;
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : step
	// inputs change 1 ns after the edge, strobes stand for one cycle
	task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic byte_w = 1'b0);
		step(1);
		bus_i.addr = a;
		bus_i.wdata = d;
		bus_i.wr_byte = byte_w;
		bus_i.wr_word = !byte_w;
		step(1);
		bus_i.wr_word = 1'b0;
		bus_i.wr_byte = 1'b0;
	endtask : wr
	task automatic rd(input logic [19:0] a, input logic [7:0] exp, input string what);
		step(1);
		bus_i.addr = a;
		bus_i.rd_byte = 1'b1;
		step(1);
		bus_i.rd_byte = 1'b0;
		check(what, {2'b00, rdata_o}, {2'b00, exp});
	endtask : rd
	// bounded wait for the interrupt (0) or the internal reset (1)
	task automatic wait_on(input logic which, input int lim, output int n);
		n = 0;
		while ((which ? chip : irq) !== 1'b1) begin
			if (n == lim) begin
				num_errors++;
				wrap_up();
			end
			step(1);
			n++;
		end
	endtask : wait_on
	task automatic t_reset_values();
		rd(ADDR_CTRL_RD, 8'h18, "ctrl");
		rd(ADDR_COUNT_RD, 8'h00, "count");
		rd(ADDR_RSTAT_RD, 8'h3f, "rstat");
		$display("reset values done");
	endtask : t_reset_values
	task automatic t_select();
		int n;
		for (int c = 0; c < 8; c++) begin
			// halt the count while changing the select, then restart it
			wr(ADDR_CNTCTL_WR, {PASS_CTRL, 5'h00, 3'(c)});
			wr(ADDR_CNTCTL_WR, {PASS_CTRL, 5'h04, 3'(c)});
			wr(ADDR_CNTCTL_WR, {PASS_COUNT, 8'hfe});
			wait_on(1'b0, 2 * divs[c] + 8, n);
			check("span", 10'(n >= divs[c] - 2 && n <= 2 * divs[c] + 2), 10'h001);
			// a zero written before the flag was read must not clear it
			wr(ADDR_CNTCTL_WR, {PASS_CTRL, 5'h04, 3'(c)});
			step(2);
			check("irq kept", 10'(irq), 10'h001);
			rd(ADDR_CTRL_RD, {5'h17, 3'(c)}, "ctrl wrap");
			wr(ADDR_CNTCTL_WR, {PASS_CTRL, 5'h00, 3'(c)});
			step(2);
			check("irq clear", 10'(irq), 10'h000);
		end
		$display("clock select done");
	endtask : t_select
	task automatic t_protect();
		wr(ADDR_CNTCTL_WR, {PASS_CTRL, 8'h27});
		wr(ADDR_CNTCTL_WR, {PASS_COUNT, 8'h80});
		wr(ADDR_CNTCTL_WR, 16'h3355);
		wr(ADDR_CNTCTL_WR, {PASS_COUNT, 8'h11}, 1'b1);
		rd(ADDR_COUNT_RD, 8'h80, "count");
		rd(ADDR_CTRL_RD, 8'h3f, "ctrl");
		step(1);
		standby_i = 1'b1;
		step(1);
		standby_i = 1'b0;
		rd(ADDR_CTRL_RD, 8'h1f, "standby ctrl");
		rd(ADDR_COUNT_RD, 8'h00, "halted count");
		$display("protection done");
	endtask : t_protect
	task automatic fire_wd();
		int n;
		int m;
		// standby stays low whenever run enable is set in watchdog mode
		wr(ADDR_CNTCTL_WR, {PASS_CTRL, 8'h60});
		wr(ADDR_CNTCTL_WR, {PASS_COUNT, 8'hfe});
		wait_on(1'b1, 12, n);
		m = 0;
		while (chip === 1'b1 && m < 600) begin
			step(1);
			m++;
		end
		check("chip len", 10'(m), 10'd518);
	endtask : fire_wd
	task automatic t_watchdog();
		wr(ADDR_RSTAT_WR, {PASS_RST_OE, 8'h40});
		step(2);
		check("oe", 10'(oe), 10'h001);
		fire_wd();
		rd(ADDR_RSTAT_RD, 8'hff, "rstat set");
		rd(ADDR_CTRL_RD, 8'h18, "ctrl after");
		wr(ADDR_RSTAT_WR, {PASS_RST_CLR, RST_CLR_DATA});
		rd(ADDR_RSTAT_RD, 8'h7f, "rstat clr");
		fire_wd();
		rst_n_i = 1'b0;
		step(1);
		rst_n_i = 1'b1;
		rd(ADDR_RSTAT_RD, 8'h3f, "pin reset");
		$display("watchdog done");
	endtask : t_watchdog
	initial begin
		step(16);
		rst_n_i = 1'b1;
		t_reset_values();
		t_select();
		t_protect();
		t_watchdog();
		wrap_up();
	end
endmodule : wdtim_top_tb
